// file: smsc_top.sv
// Status, control and interrupt logic of the master serial bus port.
// Assumes the master engine and EEPROM loader share clk_in; straps are pins.

// Notes on behaviour
// - With EEPROM boot enabled, set init-complete when loading ends or errs.
// - Unexpected NACK sets sticky no-ack flag; write one clears it.
// - Lost arbitration is retried automatically without software.
// - Sixteenth consecutive loss aborts and sets sticky lost-arbitration flag.
// - Misplaced START or STOP sets sticky misplaced-condition flag.
// - Bad EEPROM checksum sets sticky checksum flag; write one clears.
// - Missing configuration-done command also sets the checksum flag.
// - Loader write to an absent register sets sticky unmapped flag.
// - Prescaled clock period is 32 ns times the prescaler field.
// - Prescaled clock stops when the prescaler field is zero or one.
// - Prescaler starts at slow or fast value chosen by boot strap.
// - Ignore-other-masters set: transactions go on, won or lost.
// - Ignore-checksum set: checksum always passes, no checksum error.
// - Bus clock low phase lasts half the programmed period.
module smsc_top #(
  parameter int AW = 12
) (
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  input  wire smsc_pkg::smsc_req_t   req_in,
  input  wire smsc_pkg::smsc_events_t ev_in,
  input  wire logic                  boot_fast_in,
  input  wire logic                  eeprom_boot_in,
  output logic [31:0]                rd_data_out,
  output logic                       irq_out,
  output logic                       retry_arb_out,
  output logic                       abort_out,
  output logic                       ignore_other_masters_out,
  output logic                       checksum_pass_out,
  output logic                       presc_tick_out,
  output logic                       master_bus_clock_pin_out,
  output logic                       master_bus_clock_pin_oe_out
);
  localparam int EL = smsc_pkg::ERR_LSB;
  localparam int EW = smsc_pkg::ERR_W;

  // Register state
  logic [15:0]   master_clock_prescaler;
  logic          ignore_other_masters;
  logic          ignore_checksum_errors;
  logic          eeprom_init_complete;
  logic [EW-1:0] err_flags;
  logic [31:0]   irq_mask;
  logic [4:0]    losses;
  logic          drive_low;
  logic          tick;

  // Strap synchronisers and one-shot load
  logic       fast_s1, fast_s2, boot_s1, boot_s2;
  logic [1:0] settle;
  logic       strap_loaded;
  logic       eeprom_boot;

  // Address decode
  wire hit_sts  = (req_in.addr == smsc_pkg::STATUS_ADDR);
  wire hit_ctl  = (req_in.addr == smsc_pkg::CONTROL_ADDR);
  wire hit_mask = (req_in.addr == smsc_pkg::MASK_ADDR);
  wire wr_sts   = req_in.wr && hit_sts;
  wire wr_ctl   = req_in.wr && hit_ctl;
  wire wr_mask  = req_in.wr && hit_mask;

  // Checksum outcome with the ignore option
  wire csum_fail = (ev_in.checksum_bad || ev_in.cfg_done_missing)
                   && !ignore_checksum_errors;

  // Error flag sets, one per flag
  wire [EW-1:0] err_set;
  assign err_set[smsc_pkg::E_NACK] = ev_in.nack;
  assign err_set[smsc_pkg::E_LOST] = abort_out;
  assign err_set[smsc_pkg::E_MISP] = ev_in.misplaced;
  assign err_set[smsc_pkg::E_CSUM] = csum_fail;
  assign err_set[smsc_pkg::E_UNMP] = ev_in.unmapped_write;

  // Write-one-to-clear; a set in the same cycle wins
  wire [EW-1:0] err_clr    = wr_sts ? req_in.wdata[EL +: EW] : '0;
  wire [EW-1:0] next_err   = (err_flags & ~err_clr) | err_set;

  // Loader finished or stopped on an error
  wire init_end = eeprom_boot && (ev_in.init_done || csum_fail
                  || ev_in.unmapped_write);

  // Status word; unlisted bits stay zero
  wire [31:0] status_word = {2'b00, err_flags, eeprom_init_complete,
                             24'h00_0000};
  wire [31:0] control_word = {14'h0000, ignore_checksum_errors,
                              ignore_other_masters, master_clock_prescaler};

  // Read selection; unmapped addresses read zero
  wire [31:0] rd_mux = hit_sts  ? status_word  :
                       hit_ctl  ? control_word :
                       hit_mask ? irq_mask     : 32'h0000_0000;
  wire        next_irq = |(status_word & irq_mask);

  // Boot strap synchronisers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fast_s1 <= 1'b0;
      fast_s2 <= 1'b0;
      boot_s1 <= 1'b0;
      boot_s2 <= 1'b0;
    end else begin
      fast_s1 <= boot_fast_in;
      fast_s2 <= fast_s1;
      boot_s1 <= eeprom_boot_in;
      boot_s2 <= boot_s1;
    end
  end

  // Straps caught once the synchronisers have filled
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      settle       <= 2'h0;
      strap_loaded <= 1'b0;
      eeprom_boot  <= 1'b0;
    end else if (!strap_loaded) begin
      settle <= settle + 2'h1;
      if (settle == 2'(smsc_pkg::STRAP_SETTLE)) begin
        strap_loaded <= 1'b1;
        eeprom_boot  <= boot_s2;
      end
    end
  end

  // Control register with boot-time prescaler
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      master_clock_prescaler <= smsc_pkg::PRESC_SLOW;
      ignore_other_masters   <= 1'b0;
      ignore_checksum_errors <= 1'b0;
    end else if (!strap_loaded &&
                 settle == 2'(smsc_pkg::STRAP_SETTLE)) begin
      master_clock_prescaler <= fast_s2 ? smsc_pkg::PRESC_FAST
                                        : smsc_pkg::PRESC_SLOW;
    end else if (wr_ctl) begin
      master_clock_prescaler <= req_in.wdata[15:0];
      ignore_other_masters   <= req_in.wdata[smsc_pkg::IGN_MASTERS];
      ignore_checksum_errors <= req_in.wdata[smsc_pkg::IGN_CHECKSUM];
    end
  end

  // Status flags and interrupt mask
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      err_flags            <= '0;
      eeprom_init_complete <= 1'b0;
      irq_mask             <= smsc_pkg::MASK_RESET;
    end else begin
      err_flags <= next_err;
      if (init_end) begin
        eeprom_init_complete <= 1'b1;
      end
      if (wr_mask) begin
        irq_mask <= req_in.wdata;
      end
    end
  end

  // Read data for one cycle, interrupt and mirrored controls
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_out              <= 32'h0000_0000;
      irq_out                  <= 1'b0;
      ignore_other_masters_out <= 1'b0;
      checksum_pass_out        <= 1'b0;
      master_bus_clock_pin_out <= 1'b0;
    end else begin
      rd_data_out              <= req_in.rd ? rd_mux : 32'h0000_0000;
      irq_out                  <= next_irq;
      ignore_other_masters_out <= ignore_other_masters;
      checksum_pass_out        <= ignore_checksum_errors;
      master_bus_clock_pin_out <= 1'b0;
    end
  end

  // Arbitration retry counter
  smsc_arb #(
    .LIMIT (smsc_pkg::ARB_LOSS_LIMIT)
  ) u_arb (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .lost_in    (ev_in.arb_lost),
    .won_in     (ev_in.arb_won),
    .ignore_in  (ignore_other_masters),
    .retry_out  (retry_arb_out),
    .abort_out  (abort_out),
    .losses_out (losses)
  );

  // Prescaled bus clock
  smsc_presc #(
    .W   (smsc_pkg::PRESC_W),
    .CPU (smsc_pkg::CYC_PER_UNIT)
  ) u_presc (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .presc_in      (master_clock_prescaler),
    .drive_low_out (drive_low),
    .tick_out      (tick)
  );

  assign master_bus_clock_pin_oe_out = drive_low;
  assign presc_tick_out              = tick;

  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  // Helper: low phase length, and whether the prescaler held through it
  logic [17:0] low_len;
  logic [15:0] presc_q;
  logic        low_clean;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      low_len   <= '0;
      presc_q   <= '0;
      low_clean <= 1'b0;
    end else begin
      low_len   <= drive_low ? low_len + 18'h00001 : '0;
      presc_q   <= master_clock_prescaler;
      low_clean <= !drive_low || (low_clean && master_clock_prescaler == presc_q);
    end
  end

  chk_init_done_set: assert property (
    init_end |=> eeprom_init_complete ##1 eeprom_init_complete)
    else $error("init complete not set");
  chk_nack_flag_set: assert property (
    ev_in.nack |=> err_flags[smsc_pkg::E_NACK])
    else $error("nack flag not set");
  chk_retry_on_loss: assert property (
    ev_in.arb_lost && !ignore_other_masters && losses < 5'h0f
    |=> retry_arb_out && !abort_out)
    else $error("no retry after lost arbitration");
  chk_abort_sixteen: assert property (
    abort_out |-> $past(losses) == 5'h0f
    ##1 err_flags[smsc_pkg::E_LOST])
    else $error("abort not at sixteenth loss");
  chk_misplaced_flag: assert property (
    ev_in.misplaced |=> err_flags[smsc_pkg::E_MISP])
    else $error("misplaced flag not set");
  chk_checksum_flag: assert property (
    (ev_in.checksum_bad || ev_in.cfg_done_missing) && !ignore_checksum_errors
    |=> err_flags[smsc_pkg::E_CSUM])
    else $error("checksum flag not set");
  chk_unmapped_flag: assert property (
    ev_in.unmapped_write |=> err_flags[smsc_pkg::E_UNMP])
    else $error("unmapped flag not set");
  chk_clock_stops: assert property (
    (master_clock_prescaler <= 16'h0001) [*2] |-> !drive_low)
    else $error("bus clock runs with prescaler below two");
  chk_low_half_period: assert property (
    $fell(drive_low) && low_clean
    |-> $past(low_len) == 18'($past(master_clock_prescaler)) * 18'h00002 - 18'h00001)
    else $error("low phase not half the period");
  chk_ignore_masters: assert property (
    ignore_other_masters && ev_in.arb_lost |=> !retry_arb_out && !abort_out)
    else $error("arbitration acted on while ignoring masters");
  chk_ignore_checksum: assert property (
    ignore_checksum_errors && !err_flags[smsc_pkg::E_CSUM]
    |=> !err_flags[smsc_pkg::E_CSUM])
    else $error("checksum flag set while ignored");
  chk_reserved_zero: assert property (
    req_in.rd && hit_sts |=> rd_data_out[31:30] == 2'b00
    && rd_data_out[23:0] == 24'h00_0000)
    else $error("reserved status bits not zero");

  cov_abort: cover property (abort_out);
  cov_clear_race: cover property (wr_sts && |(err_set & err_clr));
  cov_irq: cover property ($rose(irq_out));
  cov_low_phase: cover property ($fell(drive_low) && low_clean);
  cov_init_on_error: cover property (init_end && !ev_in.init_done);
endmodule : smsc_top

// file: smsc_pkg.sv
// Shared constants and types for the master bus status and control block.
// Assumes a 125 MHz core clock and byte addresses on the register port.
package smsc_pkg;
  // Register byte addresses
  localparam logic [11:0] STATUS_ADDR  = 12'h424;
  localparam logic [11:0] CONTROL_ADDR = 12'h428;
  localparam logic [11:0] MASK_ADDR    = 12'h440;
  // Status field positions
  localparam int INIT_DONE_BIT = 24;
  localparam int ERR_LSB       = 25;
  localparam int ERR_W         = 5;
  // Error flag index within the error field
  localparam int E_NACK = 0;
  localparam int E_LOST = 1;
  localparam int E_MISP = 2;
  localparam int E_CSUM = 3;
  localparam int E_UNMP = 4;
  // Control field positions
  localparam int PRESC_W       = 16;
  localparam int IGN_MASTERS   = 16;
  localparam int IGN_CHECKSUM  = 17;
  // Reset and boot values of the prescaler; reset value of the interrupt mask
  localparam logic [15:0] PRESC_SLOW = 16'h0139;
  localparam logic [15:0] PRESC_FAST = 16'h0053;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  // Timing
  localparam int CLK_PERIOD_NS  = 8;
  localparam int PRESC_UNIT_NS  = 32;
  localparam int CYC_PER_UNIT   = PRESC_UNIT_NS / CLK_PERIOD_NS;
  localparam int ARB_LOSS_LIMIT = 16;
  localparam int STRAP_SETTLE   = 2;

  // Events from the master engine and the EEPROM loader, one-cycle pulses
  typedef struct packed {
    logic init_done;
    logic checksum_bad;
    logic cfg_done_missing;
    logic unmapped_write;
    logic nack;
    logic misplaced;
    logic arb_lost;
    logic arb_won;
  } smsc_events_t;

  // Register port request
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } smsc_req_t;
endpackage : smsc_pkg

// file: smsc_presc.sv
// Prescaled master bus clock generator with a 50 % duty cycle.
// Assumes the prescale value comes from a register on the same clock.
module smsc_presc #(
  parameter int W   = smsc_pkg::PRESC_W,
  parameter int CPU = smsc_pkg::CYC_PER_UNIT
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] presc_in,
  output logic              drive_low_out,
  output logic              tick_out
);
  localparam int CW = W + 2;
  logic [CW-1:0] cnt;
  // Half period in core cycles, minus one
  wire  [CW-1:0] half_m1 = CW'(presc_in) * CW'(CPU / 2) - CW'(1);
  wire           stopped = (presc_in <= W'(1));
  wire           wrap    = (cnt >= half_m1);

  // Low and high halves of equal length; idle released
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt           <= '0;
      drive_low_out <= 1'b0;
      tick_out      <= 1'b0;
    end else if (stopped) begin
      cnt           <= '0;
      drive_low_out <= 1'b0;
      tick_out      <= 1'b0;
    end else if (wrap) begin
      cnt           <= '0;
      drive_low_out <= ~drive_low_out;
      tick_out      <= drive_low_out;
    end else begin
      cnt           <= cnt + CW'(1);
      tick_out      <= 1'b0;
    end
  end
endmodule : smsc_presc

// file: smsc_arb.sv
// Counts consecutive lost arbitrations and asks for retry or abort.
// Assumes loss and win pulses from the master engine on the same clock.
module smsc_arb #(
  parameter int LIMIT = smsc_pkg::ARB_LOSS_LIMIT
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic lost_in,
  input  wire logic won_in,
  input  wire logic ignore_in,
  output logic      retry_out,
  output logic      abort_out,
  output logic [4:0] losses_out
);
  wire last_loss = (losses_out == 5'(LIMIT - 1));
  wire count_it  = lost_in && !ignore_in;

  // Retry below the limit, abort on the last loss
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      losses_out <= '0;
      retry_out  <= 1'b0;
      abort_out  <= 1'b0;
    end else begin
      retry_out <= count_it && !last_loss;
      abort_out <= count_it && last_loss;
      if (won_in || (count_it && last_loss)) begin
        losses_out <= '0;
      end else if (count_it) begin
        losses_out <= losses_out + 5'h01;
      end
    end
  end
endmodule : smsc_arb

// file: smsc_bus_model.sv
// Far-side model: other masters that win arbitration a set number of times.
// Assumes the block answers each lost attempt with a retry pulse on clk_in.
module smsc_bus_model (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             start_in,
  input  wire logic [4:0]       losses_in,
  input  wire logic             retry_in,
  output smsc_pkg::smsc_events_t ev_out
);
  logic [4:0] remaining;

  // One loss per attempt, a win once the losses are spent
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ev_out    <= '0;
      remaining <= 5'h00;
    end else begin
      ev_out <= '0;
      if (start_in) begin
        ev_out.arb_lost <= 1'b1;
        remaining       <= losses_in - 5'h01;
      end else if (retry_in && remaining != 5'h00) begin
        ev_out.arb_lost <= 1'b1;
        remaining       <= remaining - 5'h01;
      end else if (retry_in) begin
        ev_out.arb_won <= 1'b1;
      end
    end
  end
endmodule : smsc_bus_model

// file: tb_top.sv
// Self-checking bench for the master bus status and control block.
// Assumes the design files and the far-side model are compiled first.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clk_in, rst_n_in, boot_fast, eeprom_boot, bm_start;
  logic                   retry, abort, ign_m, csum_pass, tick, pin, pin_oe, irq;
  logic [4:0]             bm_losses;
  logic [31:0]            rd_data, rd_val;
  smsc_pkg::smsc_req_t    req;
  smsc_pkg::smsc_events_t tb_ev, bus_ev, ev_all, evs[5];
  logic [31:0]            bits[5];
  int                     err_total, checked, n_retry, n_abort, n, low;
  localparam logic [31:0] DONE = 32'h0100_0000;

  assign ev_all = tb_ev | bus_ev;

  smsc_top DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req), .ev_in(ev_all),
    .boot_fast_in(boot_fast), .eeprom_boot_in(eeprom_boot), .rd_data_out(rd_data),
    .irq_out(irq), .retry_arb_out(retry), .abort_out(abort),
    .ignore_other_masters_out(ign_m), .checksum_pass_out(csum_pass),
    .presc_tick_out(tick), .master_bus_clock_pin_out(pin),
    .master_bus_clock_pin_oe_out(pin_oe));

  smsc_bus_model BM (.clk_in(clk_in), .rst_n_in(rst_n_in), .start_in(bm_start),
    .losses_in(bm_losses), .retry_in(retry), .ev_out(bus_ev));

  // Clock at 125 MHz
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  // Retry and abort pulse counters
  always @(posedge clk_in) begin
    if (retry === 1'b1) n_retry++;
    if (abort === 1'b1) n_abort++;
  end

  task automatic wrap_up;
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp32

  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge clk_in);
    req.wr <= 1'b0;
  endtask : reg_wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge clk_in);
    req.rd <= 1'b0;
    #1 rd_val = rd_data;
    cmp32(rd_val, exp);
  endtask : rd_chk

  task automatic pulse(input smsc_pkg::smsc_events_t e);
    @(posedge clk_in);
    tb_ev <= e;
    @(posedge clk_in);
    tb_ev <= '0;
    repeat (3) @(posedge clk_in);
  endtask : pulse

  task automatic arb_run(input logic [4:0] k);
    n_retry = 0;
    n_abort = 0;
    @(posedge clk_in);
    bm_losses <= k;
    bm_start  <= 1'b1;
    @(posedge clk_in);
    bm_start <= 1'b0;
    repeat (80) @(posedge clk_in);
  endtask : arb_run

  // Cycles to the next tick and how many of them pull the clock low
  task automatic wait_tick;
    n = 0;
    low = 0;
    do begin
      @(posedge clk_in);
      #1 n++;
      if (pin_oe === 1'b1) low++;
    end while (tick !== 1'b1 && n < 400);
    if (n >= 400) begin
      err_total++;
      wrap_up();
    end
  endtask : wait_tick

  // Main sequence
  initial begin
    rst_n_in = 1'b0;
    req = '0;
    tb_ev = '0;
    boot_fast = 1'b0;
    eeprom_boot = 1'b1;
    bm_start = 1'b0;
    bm_losses = 5'h00;
    err_total = 0;
    checked = 0;
    evs = '{8'h08, 8'h04, 8'h40, 8'h20, 8'h10};
    bits = '{32'h0200_0000, 32'h0800_0000, 32'h1000_0000, 32'h1000_0000, 32'h2000_0000};
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    rd_chk(smsc_pkg::CONTROL_ADDR, 32'h0000_0139);
    rd_chk(smsc_pkg::STATUS_ADDR, 32'h0);
    rd_chk(12'h430, 32'h0);
    rd_chk(smsc_pkg::MASK_ADDR, 32'h0);
    reg_wr(smsc_pkg::MASK_ADDR, 32'h3e00_0000);
    pulse(8'h80);
    rd_chk(smsc_pkg::STATUS_ADDR, DONE);
    cmp32({31'h0, irq}, 32'h0);
    // Each error event sets its flag, raises the interrupt and clears by one
    for (int i = 0; i < 5; i++) begin
      pulse(evs[i]);
      rd_chk(smsc_pkg::STATUS_ADDR, DONE | bits[i]);
      cmp32({31'h0, irq}, 32'h1);
      reg_wr(smsc_pkg::STATUS_ADDR, bits[i]);
      rd_chk(smsc_pkg::STATUS_ADDR, DONE);
      cmp32({31'h0, irq}, 32'h0);
    end
    // Clear and set of one flag in the same cycle: the set wins
    @(posedge clk_in);
    tb_ev     <= 8'h08;
    req.addr  <= smsc_pkg::STATUS_ADDR;
    req.wdata <= 32'h0200_0000;
    req.wr    <= 1'b1;
    @(posedge clk_in);
    tb_ev  <= '0;
    req.wr <= 1'b0;
    rd_chk(smsc_pkg::STATUS_ADDR, DONE | 32'h0200_0000);
    reg_wr(smsc_pkg::MASK_ADDR, 32'h0);
    pulse(8'h08);
    #1 cmp32({31'h0, irq}, 32'h0);
    reg_wr(smsc_pkg::MASK_ADDR, 32'h3e00_0000);
    repeat (2) @(posedge clk_in);
    #1 cmp32({31'h0, irq}, 32'h1);
    reg_wr(smsc_pkg::STATUS_ADDR, 32'hffff_ffff);
    rd_chk(smsc_pkg::STATUS_ADDR, DONE);
    arb_run(5'h03);
    cmp32(n_retry, 32'd3);
    cmp32(n_abort, 32'd0);
    rd_chk(smsc_pkg::STATUS_ADDR, DONE);
    arb_run(5'h10);
    cmp32(n_retry, 32'd15);
    cmp32(n_abort, 32'd1);
    rd_chk(smsc_pkg::STATUS_ADDR, 32'h0500_0000);
    reg_wr(smsc_pkg::STATUS_ADDR, 32'h0400_0000);
    reg_wr(smsc_pkg::CONTROL_ADDR, 32'h0001_0139);
    repeat (2) @(posedge clk_in);
    #1 cmp32({31'h0, ign_m}, 32'h1);
    arb_run(5'h01);
    cmp32(n_retry + n_abort, 32'd0);
    rd_chk(smsc_pkg::STATUS_ADDR, DONE);
    reg_wr(smsc_pkg::CONTROL_ADDR, 32'hfffe_0139);
    rd_chk(smsc_pkg::CONTROL_ADDR, 32'h0002_0139);
    cmp32({31'h0, csum_pass}, 32'h1);
    pulse(8'h40);
    pulse(8'h20);
    rd_chk(smsc_pkg::STATUS_ADDR, DONE);
    reg_wr(smsc_pkg::CONTROL_ADDR, 32'h0000_0005);
    wait_tick();
    wait_tick();
    wait_tick();
    cmp32(n, 32'd20);
    cmp32(low, 32'd10);
    cmp32({31'h0, pin}, 32'h0);
    // Prescaler values that stop the clock
    for (int v = 0; v < 2; v++) begin
      reg_wr(smsc_pkg::CONTROL_ADDR, 32'(v));
      repeat (40) @(posedge clk_in);
      low = 0;
      n = 0;
      repeat (100) begin
        @(posedge clk_in);
        #1 if (pin_oe !== 1'b0) low++;
        if (tick !== 1'b0) n++;
      end
      cmp32(n + low, 32'd0);
    end
    rst_n_in <= 1'b0;
    boot_fast <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    rd_chk(smsc_pkg::CONTROL_ADDR, 32'h0000_0053);
    rd_chk(smsc_pkg::STATUS_ADDR, 32'h0);
    // A loader error also ends the EEPROM boot
    pulse(8'h10);
    rd_chk(smsc_pkg::STATUS_ADDR, 32'h2100_0000);
    // Without EEPROM boot the done bit never sets
    rst_n_in    <= 1'b0;
    eeprom_boot <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    pulse(8'h80);
    rd_chk(smsc_pkg::STATUS_ADDR, 32'h0);
    wrap_up();
  end
endmodule : tb_top
